/* File: src/umc_control.v */
// Behaviour
// R01 - Setting module enable activates module and clears every ping-pong indicator.
// R02 - Module enable turns on the regulator when configuration enables it; code keeps it off while suspend is set.
// R03 - While module enable is clear, other control and status bits are ignored.
// R04 - Firmware configures everything before setting module enable.
// R05 - Live flag reads 1 during single-ended zero, else 0.
// R06 - Pointer reset bit holds pointers at even banks; firmware clears it.
// R07 - Pointer reset bit ignored when no ping-pong buffering is configured.
// R08 - SETUP token sets packet disable and halts token and packet processing.
// R09 - Software can only clear packet disable; clearing resumes processing.
// R10 - Pending events stay readable from the status FIFO while disabled.
// R11 - Resume bit drives resume signalling; firmware holds it 10 ms.
// R12 - Suspend enters low power and stops engine clock; clear restores it.
// R13 - In suspend the device stays attached with transceiver outputs idle; code leaves them active while resume is also set.
// R14 - Firmware suspends after idle interrupt, resumes after activity interrupt.
// R15 - Control bits 7 and 0 always read zero.
// R16 - Writable bits and packet disable reset to zero.
// R17 - Transceiver disable bit defaults 0, keeping internal transceiver connected.
// R18 - Speed bit set selects full speed, clear selects low speed.
// R19 - Pull-up enable acts only while the internal transceiver is enabled.
// R20 - Firmware sets speed, transceiver and pull-up only during setup.
// R21 - Bus single-ended zero is synchronised before it is readable.
`timescale 1ns/100ps
`default_nettype none
`include "umc_consts.vh"
module umc_control #(
   parameter RESUME_MS = 10
) (
   input wire CLK,
   input wire RST_B,
   input wire [`UMC_ADDR_W-1:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   input wire BUS_SE0,
   input wire SETUP_TOKEN,
   input wire REGULATOR_CFG_EN,
   output wire MODULE_ACTIVE,
   output wire PINGPONG_IND_CLEAR,
   output wire PP_PTR_HOLD_EVEN,
   output wire PKT_PROCESS_EN,
   output wire STATUS_FIFO_READABLE,
   output wire RESUME_DRIVE,
   output wire ENGINE_CLK_EN,
   output wire LOW_POWER,
   output wire ATTACHED,
   output wire XCVR_IDLE,
   output wire INT_XCVR_EN,
   output wire FULL_SPEED,
   output wire PULLUP_EN,
   output wire REGULATOR_EN,
   output wire EYE_TEST,
   output wire OE_MONITOR,
   output wire [1:0] PPB_MODE
);
   reg [7:0] ctl_q;
   reg [7:0] ctl_d;
   reg [7:0] cfg_q;
   reg en_q;
   wire se0_sync;
   wire en;
   wire wr_ctl;
   wire wr_cfg;
   reg [7:0] ctl_view;

   // Decodes a select of the control register.
   function sel_control;
      input [`UMC_ADDR_W-1:0] sel_addr;
      begin
         sel_control = (sel_addr == `UMC_ADDR_CONTROL);
      end
   endfunction

   umc_sync u_se0 (
      .clk(CLK),
      .rst_b(RST_B),
      .d(BUS_SE0),
      .q(se0_sync)
   ); // R21

   assign wr_ctl = WR && sel_control(ADDR);
   assign wr_cfg = WR && (ADDR == `UMC_ADDR_CONFIG);
   assign en = ctl_q[`UMC_CTL_EN];

   always @* begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         ctl_d = (ctl_q & ~`UMC_CTL_WMASK) | (WDATA & `UMC_CTL_WMASK);
         if (!WDATA[`UMC_CTL_PKT_OFF]) begin
            ctl_d[`UMC_CTL_PKT_OFF] = 1'b0; // R09
         end
      end
      if (en && SETUP_TOKEN) begin
         ctl_d[`UMC_CTL_PKT_OFF] = 1'b1; // R08
      end
      ctl_d[`UMC_CTL_RSV_HI] = 1'b0; // R15
      ctl_d[`UMC_CTL_RSV_LO] = 1'b0; // R15
      ctl_d[`UMC_CTL_SE0] = 1'b0;
   end

   always @* begin
      ctl_view = ctl_q;
      ctl_view[`UMC_CTL_SE0] = se0_sync; // R05
   end

   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctl_q <= `UMC_RESET_BYTE; // R16
         cfg_q <= `UMC_RESET_BYTE; // R17
         en_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         en_q <= ctl_q[`UMC_CTL_EN];
         if (wr_cfg) begin
            cfg_q <= WDATA & `UMC_CFG_WMASK;
         end
      end
   end

   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         RDATA <= `UMC_RESET_BYTE;
      end else if (RD) begin
         if (sel_control(ADDR)) begin
            RDATA <= ctl_view; // R05
         end else begin
            RDATA <= cfg_q;
         end
      end else begin
         RDATA <= `UMC_RESET_BYTE;
      end
   end

   assign MODULE_ACTIVE = en; // R01
   assign PINGPONG_IND_CLEAR = en && !en_q; // R01
   assign REGULATOR_EN = en && REGULATOR_CFG_EN && !ctl_q[`UMC_CTL_SUSP]; // R02
   assign PPB_MODE = cfg_q[`UMC_CFG_PPB_HI:`UMC_CFG_PPB_LO];
   assign PP_PTR_HOLD_EVEN = en && ctl_q[`UMC_CTL_PPRST] && (PPB_MODE != `UMC_PPB_NONE); // R06 R07 R03
   assign PKT_PROCESS_EN = en && !ctl_q[`UMC_CTL_PKT_OFF] && !ctl_q[`UMC_CTL_SUSP]; // R08 R03
   assign STATUS_FIFO_READABLE = en; // R10
   assign RESUME_DRIVE = en && ctl_q[`UMC_CTL_RESUME]; // R11
   assign ENGINE_CLK_EN = en && !ctl_q[`UMC_CTL_SUSP]; // R12
   assign LOW_POWER = en && ctl_q[`UMC_CTL_SUSP]; // R12
   assign ATTACHED = en; // R13
   assign XCVR_IDLE = !en || (ctl_q[`UMC_CTL_SUSP] && !ctl_q[`UMC_CTL_RESUME]); // R13
   assign INT_XCVR_EN = !cfg_q[`UMC_CFG_TRDIS]; // R17
   assign FULL_SPEED = cfg_q[`UMC_CFG_FULL_SPD]; // R18
   assign PULLUP_EN = en && cfg_q[`UMC_CFG_PUEN] && !cfg_q[`UMC_CFG_TRDIS]; // R19
   assign EYE_TEST = en && cfg_q[`UMC_CFG_EYE];
   assign OE_MONITOR = cfg_q[`UMC_CFG_OEMON] || cfg_q[`UMC_CFG_TRDIS];
endmodule // umc_control
`default_nettype wire

/* File: shared/umc_consts.vh */
`ifndef UMC_CONSTS_VH
`define UMC_CONSTS_VH
`define UMC_ADDR_W 1
`define UMC_ADDR_CONTROL 1'h0
`define UMC_ADDR_CONFIG 1'h1
`define UMC_CTL_PPRST 6
`define UMC_CTL_SE0 5
`define UMC_CTL_PKT_OFF 4
`define UMC_CTL_EN 3
`define UMC_CTL_RESUME 2
`define UMC_CTL_SUSP 1
`define UMC_CTL_RSV_HI 7
`define UMC_CTL_RSV_LO 0
`define UMC_CFG_EYE 7
`define UMC_CFG_OEMON 6
`define UMC_CFG_PUEN 4
`define UMC_CFG_TRDIS 3
`define UMC_CFG_FULL_SPD 2
`define UMC_CFG_PPB_HI 1
`define UMC_CFG_PPB_LO 0
`define UMC_CTL_WMASK 8'h4e
`define UMC_CFG_WMASK 8'hdf
`define UMC_PPB_NONE 2'h0
`define UMC_RESET_BYTE 8'h00
`endif

/* File: src/umc_sync.v */
`timescale 1ns/100ps
`default_nettype none
module umc_sync (
   input wire clk,
   input wire rst_b,
   input wire d,
   output wire q
);
   reg s1_q;
   reg s2_q;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end
   assign q = s2_q;
endmodule // umc_sync
`default_nettype wire

/* File: bench/umc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module umc_host_model (
   input wire logic CLK,
   output logic SE0,
   output logic TOK
);
   initial {SE0, TOK} = 2'b00;
   task setup;
      @(posedge CLK) TOK <= 1'b1;
      @(posedge CLK) TOK <= 1'b0;
   endtask
   task se0(input logic v);
      @(posedge CLK) SE0 <= v;
   endtask
endmodule // umc_host_model
`default_nettype wire

/* File: bench/umc_control_properties.sv */
`timescale 1ns/100ps
`default_nettype none
`include "umc_consts.vh"
module umc_control_properties (
   input wire logic CLK, RST_B, WR, RD, BUS_SE0, SETUP_TOKEN,
   input wire logic [`UMC_ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA, RDATA,
   input wire logic MODULE_ACTIVE, PINGPONG_IND_CLEAR, PKT_PROCESS_EN, RESUME_DRIVE,
   input wire logic LOW_POWER, PULLUP_EN, INT_XCVR_EN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_enable_ind_clear: assert property ($rose(MODULE_ACTIVE) |-> PINGPONG_IND_CLEAR ##1 !PINGPONG_IND_CLEAR)
      else $error("no clear");
   a_off_quiet: assert property (!MODULE_ACTIVE |-> !(PKT_PROCESS_EN || RESUME_DRIVE || LOW_POWER))
      else $error("off");
   a_se0_live: assert property ((BUS_SE0 [*4] ##0 (RD && !ADDR)) |=> RDATA[5]) else $error("se0");
   a_setup_lock: assert property (SETUP_TOKEN && MODULE_ACTIVE |=> !PKT_PROCESS_EN) else $error("tok");
   a_resume_drive: assert property (WR && !ADDR |=> RESUME_DRIVE == (($past(WDATA) & 8'h0c) == 8'h0c))
      else $error("res");
   a_suspend_power: assert property (WR && !ADDR |=> LOW_POWER == (($past(WDATA) & 8'h0a) == 8'h0a))
      else $error("susp");
   a_unimpl_zero: assert property (RD && !ADDR |=> !RDATA[7] && !RDATA[0]) else $error("unimpl");
   a_pullup_gate: assert property (PULLUP_EN |-> INT_XCVR_EN && MODULE_ACTIVE) else $error("pu");
endmodule // umc_control_properties
bind umc_control umc_control_properties u_props (.*);
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "umc_consts.vh"
module tb;
   logic CLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0, REGULATOR_CFG_EN = 1'b1;
   logic [`UMC_ADDR_W-1:0] ADDR = '0;
   logic [7:0] WDATA = 8'h00;
   wire [7:0] RDATA;
   wire [1:0] PPB_MODE;
   wire BUS_SE0, SETUP_TOKEN, MODULE_ACTIVE, PINGPONG_IND_CLEAR, PP_PTR_HOLD_EVEN, PKT_PROCESS_EN, STATUS_FIFO_READABLE;
   wire RESUME_DRIVE, ENGINE_CLK_EN, LOW_POWER, ATTACHED, XCVR_IDLE, INT_XCVR_EN, FULL_SPEED, PULLUP_EN;
   wire REGULATOR_EN, EYE_TEST, OE_MONITOR;
   wire [17:0] st = {PPB_MODE, PP_PTR_HOLD_EVEN, RESUME_DRIVE, LOW_POWER, PKT_PROCESS_EN, PULLUP_EN, REGULATOR_EN,
      INT_XCVR_EN, FULL_SPEED, MODULE_ACTIVE, STATUS_FIFO_READABLE, ENGINE_CLK_EN, ATTACHED, XCVR_IDLE, EYE_TEST,
      OE_MONITOR, PINGPONG_IND_CLEAR};
   int err_total = 0, n_tests = 0, cyc = 0;
   always #10 CLK = ~CLK;
   umc_control uut (.*);
   umc_host_model host (.CLK(CLK), .SE0(BUS_SE0), .TOK(SETUP_TOKEN));
   task close_out;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string s, input logic [17:0] e, input logic [17:0] v);
      n_tests++;
      if (v !== e) begin
         err_total++;
         $display("ERROR %s exp %h got %h", s, e, v);
      end
   endtask
   task wr8(input logic [`UMC_ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge CLK) begin ADDR <= a; WDATA <= d; WR <= 1'b1; end
      @(posedge CLK) WR <= 1'b0;
   endtask
   task rc(input logic [`UMC_ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge CLK) begin ADDR <= a; RD <= 1'b1; end
      @(posedge CLK) RD <= 1'b0;
      @(negedge CLK) chk("rdata", {10'h000, e}, {10'h000, RDATA});
   endtask
   task cs(input logic [17:0] e);
      @(negedge CLK) chk("status", e, st);
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 3000) begin err_total++; close_out; end
   end
   initial begin
      repeat (6) @(posedge CLK);
      RST_B <= 1'b1;
      cs(18'h00208); rc(0, 8'h00); rc(1, 8'h00);
      $display("test reset done");
      wr8(1, 8'hff); rc(1, 8'hdf); cs(18'h3010a);
      wr8(1, 8'h15); cs(18'h10308);
      wr8(0, 8'hff); rc(0, 8'h4e); cs(18'h1ebd0);
      wr8(0, 8'h08); cs(18'h11ff0);
      wr8(0, 8'h0a); cs(18'h12bd8); wr8(0, 8'h08);
      $display("test enable done");
      host.setup(); cs(18'h10ff0); rc(0, 8'h18);
      wr8(0, 8'h18); rc(0, 8'h18); wr8(0, 8'h08); rc(0, 8'h08); wr8(0, 8'h18); rc(0, 8'h08);
      $display("test setup done");
      host.se0(1'b1); repeat (4) @(posedge CLK); rc(0, 8'h28); host.se0(1'b0);
      $display("test se0 done");
      wr8(0, 8'h00); wr8(1, 8'h14); wr8(0, 8'h48); cs(18'h01ff1);
      wr8(0, 8'h46); host.setup(); cs(18'h00308); rc(0, 8'h46);
      $display("test off done");
      @(posedge CLK) RST_B <= 1'b0;
      @(posedge CLK) RST_B <= 1'b1;
      cs(18'h00208); rc(0, 8'h00); rc(1, 8'h00);
      $display("test reset again done");
      close_out;
   end
endmodule // tb
`default_nettype wire
